// [dls_pkg.sv]
// package: constants and state types of the display list sequencer
`default_nettype none
package dls_pkg;
  // ------------------------------------------------------------
  // instruction byte fields
  // ------------------------------------------------------------
  localparam int DLS_BIT_IRQ = 7;
  localparam int DLS_BIT_RELOAD = 6;
  localparam int DLS_BIT_VSCROLL = 5;
  localparam int DLS_BIT_HSCROLL = 4;
  localparam int DLS_CNT_HI = 6;
  localparam int DLS_CNT_LO = 4;
  localparam logic [3:0] DLS_MODE_BLANK = 4'h0;
  localparam logic [3:0] DLS_MODE_JUMP = 4'h1;
  // ------------------------------------------------------------
  // pointer wrap widths
  // ------------------------------------------------------------
  localparam int DLS_LIST_INC_W = 10;
  localparam int DLS_SCAN_INC_W = 12;
  // ------------------------------------------------------------
  // scan lines per playfield mode, minus one
  // ------------------------------------------------------------
  localparam logic [3:0] DLS_LINES_M1 [16] = '{
    4'h0, 4'h0, 4'h7, 4'h9, 4'h7, 4'hf, 4'h7, 4'hf,
    4'h7, 4'h3, 4'h3, 4'h1, 4'h0, 4'h1, 4'h0, 4'h0};
  // ------------------------------------------------------------
  // sequencer state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_LINE, ST_IR, ST_LO, ST_HI} dls_st_t;
  typedef struct packed {
    dls_st_t st;
    logic [15:0] ptr;
    logic [7:0] ir;
    logic [7:0] lo;
    logic [15:0] scan;
    logic [4:0] remain;
    logic in_line;
    logic prev_vs;
    logic jump_wait_blank;
    logic vb_d;
    logic irq;
    logic scan_ld;
  } dls_state_t;
  localparam dls_state_t DLS_STATE_RST = '0;
endpackage : dls_pkg
`default_nettype wire

// [dls_dec_if.sv]
// interface: instruction byte and its decoded fields
`default_nettype none
interface dls_dec_if;
  logic [7:0] instr;
  logic irq_req;
  logic reload;
  logic vs_en;
  logic hs_en;
  logic [3:0] mode;
  logic is_blank;
  logic is_jump;
  logic need_ops;
  logic [3:0] lines_m1;
  modport dec (input instr, output irq_req, reload, vs_en, hs_en, mode, is_blank,
    is_jump, need_ops, lines_m1);
  modport seq (output instr, input irq_req, reload, vs_en, hs_en, mode, is_blank,
    is_jump, need_ops, lines_m1);
endinterface : dls_dec_if
`default_nettype wire

// [dls_decoder.sv]
// module: combinational instruction byte decoder
`default_nettype none
module dls_decoder import dls_pkg::*; (
  dls_dec_if.dec d
);
  logic blank_or_jump;
  assign d.mode = d.instr[3:0];
  assign d.is_blank = (d.mode == DLS_MODE_BLANK);
  assign d.is_jump = (d.mode == DLS_MODE_JUMP);
  assign blank_or_jump = d.is_blank | d.is_jump;
  assign d.irq_req = d.instr[DLS_BIT_IRQ];
  assign d.reload = d.instr[DLS_BIT_RELOAD] & ~d.is_blank;
  assign d.vs_en = d.instr[DLS_BIT_VSCROLL] & ~blank_or_jump;
  assign d.hs_en = d.instr[DLS_BIT_HSCROLL] & ~blank_or_jump;
  assign d.need_ops = d.is_jump | d.reload;
  assign d.lines_m1 = d.is_blank ? {1'b0, d.instr[DLS_CNT_HI:DLS_CNT_LO]} :
    DLS_LINES_M1[d.mode];
endmodule : dls_decoder
`default_nettype wire

// [display_list_sequencer.sv]
// module: display list fetch, pointer and mode line sequencing
`default_nettype none
// Overview of operation
// - fetch byte at mode line end, advance
// - advance wraps low 10 bits only
// - jump loads all sixteen pointer bits
// - host pointer writes act immediately
// - no stored list start address
// - byte splits into irq, reload, scrolls, mode
// - irq at final scan line start
// - modes 2 to F are playfield lines
// - reload loads scan pointer, low first
// - scan fetch wraps within 4K block
// - blank mode gives one to eight lines
// - blank clears scrolls and reload bits
// - jump reads two bytes, shows blank
// - lengthened jump refetches address each line
// - jumps honour interrupt request bit
// - jump with bit 6 waits vertical blank
// - fetch disabled replays previous byte
module display_list_sequencer import dls_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic line_start_i,
  input wire logic vblank_i,
  input wire logic fetch_enable_i,
  input wire logic [3:0] vscroll_extra_i,
  input wire logic pf_advance_i,
  input wire logic list_pointer_low_wr_i,
  input wire logic list_pointer_high_wr_i,
  input wire logic [7:0] ptr_wdata_i,
  output logic mem_req_o,
  output logic [15:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_rdata_i,
  output logic [15:0] list_pointer_o,
  output logic [7:0] instruction_latch_o,
  output logic line_interrupt_request_o,
  output logic [3:0] mode_o,
  output logic playfield_line_o,
  output logic vertical_scroll_enable_o,
  output logic horizontal_scroll_enable_o,
  output logic blank_line_o,
  output logic [4:0] lines_left_o,
  output logic [15:0] scan_addr_o,
  output logic scan_pointer_reload_o,
  output logic jump_wait_blank_o
);
  // ------------------------------------------------------------
  // state and decoder
  // ------------------------------------------------------------
  dls_state_t q_r;
  dls_state_t q_nxt;
  dls_dec_if dec ();
  dls_decoder u_dec (
    .d(dec)
  );

  logic fetch_on;
  logic start_line;
  logic [4:0] extra;
  logic [15:0] ptr_adv;
  logic taken;

  // the byte being fetched is decoded in the same cycle it lands
  assign dec.instr = (q_r.st == ST_IR) ? mem_rdata_i : q_r.ir;
  assign fetch_on = fetch_enable_i & ~q_r.jump_wait_blank;
  assign taken = mem_req_o & mem_ack_i;
  assign ptr_adv = {q_r.ptr[15:DLS_LIST_INC_W], q_r.ptr[DLS_LIST_INC_W-1:0] + 10'h001};

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    q_nxt.irq = 1'b0;
    q_nxt.scan_ld = 1'b0;
    q_nxt.vb_d = vblank_i;
    start_line = 1'b0;
    extra = 5'h00;
    if (pf_advance_i) begin
      q_nxt.scan = {q_r.scan[15:DLS_SCAN_INC_W], q_r.scan[DLS_SCAN_INC_W-1:0] + 12'h001};
    end
    case (q_r.st)
      ST_LINE: begin
        if (line_start_i && !vblank_i) begin
          if (q_r.remain != 5'h00) begin
            q_nxt.remain = q_r.remain - 5'h01;
            // irq on last scan line of mode line
            if (q_r.remain == 5'h01 && dec.irq_req) begin
              q_nxt.irq = 1'b1;
            end
            if (dec.is_jump && fetch_on) begin
              q_nxt.st = ST_LO;
            end
          end else if (fetch_on) begin
            // new instruction at mode line end
            q_nxt.st = ST_IR;
            q_nxt.in_line = 1'b0;
          end else begin
            start_line = 1'b1;
          end
        end
      end
      ST_IR: begin
        if (taken) begin
          q_nxt.ir = mem_rdata_i;
          q_nxt.ptr = ptr_adv;
          if (dec.need_ops) begin
            q_nxt.st = ST_LO;
          end else begin
            start_line = 1'b1;
          end
        end
      end
      ST_LO: begin
        if (taken) begin
          q_nxt.lo = mem_rdata_i;
          q_nxt.ptr = ptr_adv;
          q_nxt.st = ST_HI;
        end
      end
      ST_HI: begin
        if (taken) begin
          q_nxt.st = ST_LINE;
          if (dec.is_jump) begin
            q_nxt.ptr = {mem_rdata_i, q_r.lo};
            q_nxt.jump_wait_blank = q_r.ir[DLS_BIT_RELOAD];
          end else begin
            q_nxt.ptr = ptr_adv;
            q_nxt.scan = {mem_rdata_i, q_r.lo};
            q_nxt.scan_ld = 1'b1;
          end
          start_line = ~q_r.in_line;
        end
      end
      default: begin
        q_nxt.st = ST_LINE;
      end
    endcase
    if (start_line) begin
      q_nxt.st = ST_LINE;
      q_nxt.in_line = 1'b1;
      // scroll region end stretches the line
      if (q_r.prev_vs && !dec.vs_en) begin
        extra = {1'b0, vscroll_extra_i};
      end
      q_nxt.remain = {1'b0, dec.lines_m1} + extra;
      q_nxt.prev_vs = dec.vs_en;
      if (q_nxt.remain == 5'h00 && dec.irq_req) begin
        q_nxt.irq = 1'b1;
      end
    end
    // vertical blank releases suspension, drops bit 6
    if (vblank_i && !q_r.vb_d) begin
      q_nxt.jump_wait_blank = 1'b0;
      q_nxt.ir[DLS_BIT_RELOAD] = 1'b0;
    end
    // host writes win over any advance
    if (list_pointer_low_wr_i) begin
      q_nxt.ptr[7:0] = ptr_wdata_i;
    end
    if (list_pointer_high_wr_i) begin
      q_nxt.ptr[15:8] = ptr_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q_r <= DLS_STATE_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign mem_req_o = (q_r.st != ST_LINE);
  assign mem_addr_o = q_r.ptr;
  assign list_pointer_o = q_r.ptr;
  assign instruction_latch_o = q_r.ir;
  assign line_interrupt_request_o = q_r.irq;
  assign mode_o = dec.mode;
  // modes 2 to F are playfield
  assign playfield_line_o = ~dec.is_blank & ~dec.is_jump;
  assign vertical_scroll_enable_o = dec.vs_en;
  assign horizontal_scroll_enable_o = dec.hs_en;
  assign blank_line_o = dec.is_blank | dec.is_jump;
  assign lines_left_o = q_r.remain;
  assign scan_addr_o = q_r.scan;
  assign scan_pointer_reload_o = q_r.scan_ld;
  assign jump_wait_blank_o = q_r.jump_wait_blank;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic no_wr;
  assign no_wr = ~list_pointer_low_wr_i & ~list_pointer_high_wr_i;

  a_fetch_wrap_adv: assert property (
    (q_r.st == ST_IR && taken && no_wr) |=>
      list_pointer_o == {$past(q_r.ptr[15:10]), $past(q_r.ptr[9:0]) + 10'h001})
    else $error("list pointer advance not wrapped in 1K");
  a_jump_target: assert property (
    (q_r.st == ST_HI && taken && dec.is_jump && no_wr) |=>
      list_pointer_o == {$past(mem_rdata_i), $past(q_r.lo)})
    else $error("jump did not load full pointer");
  a_host_write_now: assert property (
    list_pointer_high_wr_i |=> list_pointer_o[15:8] == $past(ptr_wdata_i))
    else $error("host pointer write not immediate");
  a_irq_last_line: assert property (
    line_interrupt_request_o |-> lines_left_o == 5'h00 && instruction_latch_o[7])
    else $error("interrupt outside final scan line");
  a_reload_scan: assert property (
    (q_r.st == ST_HI && taken && !dec.is_jump) |=>
      scan_pointer_reload_o && scan_addr_o == {$past(mem_rdata_i), $past(q_r.lo)})
    else $error("scan pointer reload wrong");
  a_scan_block_wrap: assert property (
    (pf_advance_i && !(q_r.st == ST_HI && taken)) |=> $stable(scan_addr_o[15:12]))
    else $error("scan address left its 4K block");
  a_blank_count: assert property (
    (q_r.st == ST_IR && taken && mem_rdata_i[3:0] == 4'h0 && !q_r.prev_vs) |=>
      lines_left_o == {2'b00, $past(mem_rdata_i[6:4])})
    else $error("blank line count wrong");
  a_jvb_no_fetch: assert property (
    jump_wait_blank_o |-> !mem_req_o)
    else $error("fetch while waiting for blank");
  a_disabled_replay: assert property (
    (!fetch_enable_i && q_r.st == ST_LINE && no_wr) |=>
      q_r.st == ST_LINE && $stable(list_pointer_o))
    else $error("fetch while list fetching disabled");
endmodule : display_list_sequencer
`default_nettype wire

// [dls_mem_model.sv]
// behavioural system memory answering list fetches after a set delay
`default_nettype none
module dls_mem_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic [15:0] addr_i,
  input wire logic [3:0] delay_i,
  output logic ack_o,
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [65536];
  logic [3:0] wait_r = 4'h0;
  initial ack_o = 1'b0;
  initial rdata_o = 8'h5a;
  // released bus toggles so a stale byte never passes for an answer
  always @(posedge clk_i) begin
    if (!rst_n_i || req_i !== 1'b1 || ack_o) begin
      ack_o <= 1'b0;
      wait_r <= 4'h0;
      rdata_o <= ~rdata_o;
    end else if (wait_r >= delay_i) begin
      ack_o <= 1'b1;
      rdata_o <= mem[addr_i];
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule : dls_mem_model
`default_nettype wire

// [display_list_sequencer_tb_top.sv]
// testbench: display list sequencer against a behavioural memory
`default_nettype none
module display_list_sequencer_tb_top import dls_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, ls = 1'b0, vb = 1'b0, fen = 1'b0, pfa = 1'b0;
  logic wl = 1'b0, wh = 1'b0, req, ack, irq, rld, jwb, pf, bl, vs, hs;
  logic [7:0] wd = 8'h00, rd, ir, b;
  logic [15:0] addr, ptr, scan, ep;
  logic [3:0] mode, dly = 4'h0, vx = 4'h0;
  logic [4:0] left;
  logic [31:0] lfsr = 32'h2f5fa916;
  int fails = 0, cmp_count = 0, irqs = 0, reqs = 0, r0, i0;
  always #2 clk = ~clk;
  always @(posedge clk) if (irq === 1'b1) irqs <= irqs + 1;
  always @(posedge req) reqs <= reqs + 1;
  display_list_sequencer dut_u (
    .ref_clk_i(clk), .rst_n_i(rst_n), .line_start_i(ls), .vblank_i(vb),
    .fetch_enable_i(fen), .vscroll_extra_i(vx), .pf_advance_i(pfa),
    .list_pointer_low_wr_i(wl), .list_pointer_high_wr_i(wh), .ptr_wdata_i(wd),
    .mem_req_o(req), .mem_addr_o(addr), .mem_ack_i(ack), .mem_rdata_i(rd),
    .list_pointer_o(ptr), .instruction_latch_o(ir), .line_interrupt_request_o(irq),
    .mode_o(mode), .playfield_line_o(pf), .vertical_scroll_enable_o(vs),
    .horizontal_scroll_enable_o(hs), .blank_line_o(bl), .lines_left_o(left),
    .scan_addr_o(scan), .scan_pointer_reload_o(rld), .jump_wait_blank_o(jwb));
  dls_mem_model mem_u (.clk_i(clk), .rst_n_i(rst_n), .req_i(req), .addr_i(addr),
    .delay_i(dly), .ack_o(ack), .rdata_o(rd));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd
  // pointer advance keeps the upper six bits
  function automatic logic [15:0] nx(input logic [15:0] p);
    return {p[15:10], p[9:0] + 10'h1};
  endfunction : nx
  task automatic line();
    @(posedge clk) ls <= 1'b1;
    @(posedge clk) ls <= 1'b0;
    @(negedge clk);
    for (int i = 0; i < 80 && req !== 1'b0; i++) @(negedge clk);
    // settle past the edge so counters and registers are read after update
    @(posedge clk);
    @(negedge clk);
  endtask : line
  task automatic drain();
    for (int i = 0; i < 20 && left !== 5'h00; i++) line();
  endtask : drain
  // host side only touches the pointer while fetching is off
  task automatic wr_ptr(input logic [15:0] p);
    @(posedge clk) begin wl <= 1'b1; wd <= p[7:0]; end
    @(posedge clk) begin wl <= 1'b0; wh <= 1'b1; wd <= p[15:8]; end
    @(posedge clk) wh <= 1'b0;
    ep = p;
  endtask : wr_ptr
  task automatic run_instr(input logic [7:0] b, input logic [7:0] lo, input logic [7:0] hi);
    logic [15:0] p1, p2;
    logic jmp, pfl, ops;
    p1 = nx(ep);
    p2 = nx(p1);
    jmp = b[3:0] == DLS_MODE_JUMP;
    pfl = b[3:0] > DLS_MODE_JUMP;
    ops = jmp || (pfl && b[6]);
    mem_u.mem[ep] = b;
    mem_u.mem[p1] = lo;
    mem_u.mem[p2] = hi;
    i0 = irqs;
    line();
    ep = jmp ? {hi, lo} : ops ? nx(p2) : p1;
    chk("ir", 16'(ir), 16'(b)); // fetched byte
    chk("mode", 16'(mode), 16'(b[3:0])); // mode field
    chk("flags", 16'({pf, bl, vs, hs}), 16'({pfl, !pfl, pfl & b[5], pfl & b[4]}));
    chk("left", 16'(left), 16'(b[3:0] == 4'h0 ? {1'b0, b[6:4]} : DLS_LINES_M1[b[3:0]]));
    chk("ptr", ptr, ep); // pointer
    if (pfl && b[6]) chk("scan", scan, {hi, lo}); // scan reload
    drain();
    chk("irq", 16'(irqs - i0), 16'(b[7])); // interrupt count
  endtask : run_instr
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("ptr_rst", ptr, 16'h0000); // reset value
    wr_ptr(16'h07fe);
    fen <= 1'b1;
    run_instr(8'h4e, 8'hfe, 8'h1f);
    repeat (3) begin
      @(posedge clk) pfa <= 1'b1;
      @(posedge clk) pfa <= 1'b0;
    end
    @(posedge clk);
    chk("scan_wrap", scan, 16'h1001); // 4K wrap
    run_instr(8'h81, 8'h34, 8'h12);
    run_instr(8'h70, rnd(), rnd());
    // scroll region ends on a jump: two added lines, each refetching
    run_instr(8'h2e, 8'h00, 8'h00);
    vx <= 4'h2;
    mem_u.mem[ep] = 8'h01;
    mem_u.mem[nx(ep)] = 8'h00;
    mem_u.mem[nx(nx(ep))] = 8'h20;
    mem_u.mem[16'h2000] = 8'h10;
    mem_u.mem[16'h2001] = 8'h20;
    mem_u.mem[16'h2010] = 8'h00;
    mem_u.mem[16'h2011] = 8'h20;
    line();
    chk("vs_left", 16'(left), 16'h0002); // extended jump
    chk("vs_ptr", ptr, 16'h2000); // jump target
    line();
    chk("chain_ptr", ptr, 16'h2010); // refetched address
    vx <= 4'h0;
    drain();
    chk("chain_ptr2", ptr, 16'h2000); // refetched again
    ep = 16'h2000;
    repeat (24) begin
      b = rnd();
      if (b[3:0] == DLS_MODE_JUMP) b[3:0] = 4'h2;
      dly <= 4'(rnd());
      run_instr(b, rnd(), rnd());
    end
    fen <= 1'b0;
    r0 = reqs;
    line();
    chk("off_ir", 16'(ir), 16'(b)); // replayed byte
    chk("off_ptr", ptr, ep); // pointer held
    chk("off_req", 16'(reqs - r0), 16'h0000); // no fetch
    drain();
    fen <= 1'b1;
    run_instr(8'hc1, 8'h00, 8'h30);
    chk("jwb", 16'(jwb), 16'h0001); // suspended
    r0 = reqs;
    i0 = irqs;
    line();
    line();
    chk("jwb_req", 16'(reqs - r0), 16'h0000); // no fetch
    chk("jwb_irq", 16'(irqs - i0), 16'h0002); // irq per replay
    vb <= 1'b1;
    repeat (3) @(posedge clk);
    chk("jwb_vb", 16'(jwb), 16'h0000); // released
    chk("ir_vb", 16'(ir), 16'h0081); // bit 6 cleared
    vb <= 1'b0;
    finish_test();
  end
  // more than twenty times the longest expected run
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    finish_test();
  end
endmodule : display_list_sequencer_tb_top
`default_nettype wire
